// ==== skip_decrement_and_set_ops.v ====
`timescale 1ns/1ns
`default_nettype none
`include "skip_ops_defs.vh"

module skip_decrement_and_set_ops
(
  input wire sys_clk,
  input wire reset,
  input wire op_valid,
  input wire [1:0] op_code,
  input wire [`ADDR_W-1:0] op_addr,
  input wire [`BIT_SEL_W-1:0] op_bit,
  input wire [`DATA_W-1:0] mem_rdata,
  input wire [`DATA_W-1:0] pc_in,
  output reg mem_we,
  output reg [`ADDR_W-1:0] mem_addr,
  output reg [`DATA_W-1:0] mem_wdata,
  output reg discard_prefetch,
  output reg pc_advance,
  output reg [`DATA_W-1:0] pc_next,
  output reg busy,
  output reg [1:0] op_cycles
);

  // ****************************************
  // State encoding
  // ****************************************
  // Only one wait state exists: the dummy slot after a zero result
  localparam ST_RUN = 1'b0;
  localparam ST_DUMMY = 1'b1;

  reg state;
  reg next_state;
  reg [`DATA_W-1:0] dec_value;
  reg [`DATA_W-1:0] bit_mask;
  reg dec_zero;
  reg accept;
  reg is_dec;
  reg is_set_byte;
  reg is_set_bit;
  reg next_mem_we;
  reg [`ADDR_W-1:0] next_mem_addr;
  reg [`DATA_W-1:0] next_mem_wdata;
  reg next_discard_prefetch;
  reg next_pc_advance;
  reg [`DATA_W-1:0] next_pc_next;
  reg next_busy;
  reg [1:0] next_op_cycles;

  // ****************************************
  // Operation decode
  // ****************************************
  always @*
  begin
    accept = op_valid && (state == ST_RUN);
    is_dec = 1'b0;
    is_set_byte = 1'b0;
    is_set_bit = 1'b0;
    case (op_code)
      `OP_DEC_SKIP:
      begin
        is_dec = 1'b1;
      end
      `OP_SET_BYTE:
      begin
        is_set_byte = 1'b1;
      end
      `OP_SET_BIT:
      begin
        is_set_bit = 1'b1;
      end
      default:
      begin
        is_dec = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Datapath
  // ****************************************
  // Read data is combinational from memory, so the new value
  // is ready in the same cycle the operation is taken
  always @*
  begin
    dec_value = mem_rdata - `DEC_STEP;
    dec_zero = (dec_value == `ZERO_BYTE);
    bit_mask = `BIT_BASE << op_bit;
  end

  // ****************************************
  // Dummy cycle control
  // ****************************************
  always @*
  begin
    next_state = state;
    case (state)
      ST_RUN:
      begin
        if (accept && is_dec && dec_zero)
        begin
          next_state = ST_DUMMY;
        end
      end
      ST_DUMMY:
      begin
        // Only one dummy slot, never two
        next_state = ST_RUN;
      end
      default:
      begin
        next_state = ST_RUN;
      end
    endcase
  end

  // ****************************************
  // Memory write request
  // ****************************************
  // Address and data hold between operations; only the strobe pulses
  always @*
  begin
    next_mem_we = 1'b0;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    if (accept)
    begin
      next_mem_addr = op_addr;
      if (is_dec)
      begin
        next_mem_we = 1'b1;
        next_mem_wdata = dec_value;
      end
      else if (is_set_byte)
      begin
        next_mem_we = 1'b1;
        next_mem_wdata = `ALL_ONES;
      end
      else if (is_set_bit)
      begin
        next_mem_we = 1'b1;
        next_mem_wdata = mem_rdata | bit_mask;
      end
    end
  end

  // ****************************************
  // Instruction sequencing
  // ****************************************
  // The dummy slot also advances the counter past the discarded word;
  // the caller must present the updated pc_in in that slot
  always @*
  begin
    next_discard_prefetch = 1'b0;
    next_pc_advance = 1'b0;
    next_pc_next = pc_next;
    next_op_cycles = op_cycles;
    next_busy = (next_state == ST_DUMMY);
    if (accept)
    begin
      next_pc_advance = 1'b1;
      next_pc_next = pc_in + `PC_STEP;
      next_op_cycles = `CYCLES_NO_SKIP;
      if (is_dec && dec_zero)
      begin
        next_discard_prefetch = 1'b1;
        next_op_cycles = `CYCLES_SKIP;
      end
    end
    else if (state == ST_DUMMY)
    begin
      next_pc_advance = 1'b1;
      next_pc_next = pc_in + `PC_STEP;
    end
  end

  // ****************************************
  // Registered memory request
  // ****************************************
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      mem_we <= 1'b0;
      mem_addr <= `ZERO_BYTE;
      mem_wdata <= `ZERO_BYTE;
    end
    else
    begin
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
    end
  end

  // ****************************************
  // Registered sequencing
  // ****************************************
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= ST_RUN;
      discard_prefetch <= 1'b0;
      pc_advance <= 1'b0;
      pc_next <= `ZERO_BYTE;
      busy <= 1'b0;
      op_cycles <= `CYCLES_RESET;
    end
    else
    begin
      state <= next_state;
      discard_prefetch <= next_discard_prefetch;
      pc_advance <= next_pc_advance;
      pc_next <= next_pc_next;
      busy <= next_busy;
      op_cycles <= next_op_cycles;
    end
  end

endmodule

`default_nettype wire

// ==== skip_ops_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// Checker
// ****
module skip_ops_asserts(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic op_valid,
  input wire logic [1:0] op_code,
  input wire logic [2:0] op_bit,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic discard_prefetch,
  input wire logic pc_advance,
  input wire logic busy,
  input wire logic [1:0] op_cycles);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire take = op_valid && !busy;
  sequence dec_s; take && op_code == 2'h1; endsequence
  sequence dec_zero_s; take && op_code == 2'h1 && mem_rdata == 8'h01; endsequence
  sequence dec_live_s; take && op_code == 2'h1 && mem_rdata != 8'h01; endsequence
  sequence dummy_s;
    discard_prefetch && busy && op_cycles == 2'h2 ##1 !busy && pc_advance && !mem_we;
  endsequence
  dec_write_a: assert property (
    dec_s |=> mem_we && mem_wdata == $past(mem_rdata) - 8'h01) else $error("dec write");
  zero_skip_a: assert property (
    dec_zero_s |=> dummy_s) else $error("zero skip");
  no_skip_a: assert property (
    dec_live_s |=> !busy && !discard_prefetch && op_cycles == 2'h1) else $error("no skip");
  take_step_a: assert property (
    take |=> pc_advance) else $error("take step");
  set_byte_a: assert property (
    take && op_code == 2'h2 |=> mem_we && mem_wdata == 8'hFF) else $error("set byte");
  set_bit_a: assert property (
    take && op_code == 2'h3 |=> mem_we && mem_wdata == ($past(mem_rdata) | 8'h01 << $past(op_bit)))
    else $error("set bit");
  one_drop_a: assert property (
    op_valid && busy |=> !mem_we && !discard_prefetch) else $error("one drop");
endmodule
bind skip_decrement_and_set_ops skip_ops_asserts skip_ops_asserts_i(
  .sys_clk(sys_clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
  .op_bit(op_bit), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata),
  .discard_prefetch(discard_prefetch), .pc_advance(pc_advance), .busy(busy),
  .op_cycles(op_cycles));
`default_nettype wire

// ==== skip_ops_defs.vh ====
`ifndef SKIP_OPS_DEFS_VH
`define SKIP_OPS_DEFS_VH
// Operation codes presented on op_code
`define OP_NONE 2'h0
`define OP_DEC_SKIP 2'h1
`define OP_SET_BYTE 2'h2
`define OP_SET_BIT 2'h3
// Data and address widths
`define DATA_W 8
`define ADDR_W 8
`define BIT_SEL_W 3
// Values
`define ALL_ONES 8'hFF
`define DEC_STEP 8'h01
`define ZERO_BYTE 8'h00
// Machine cycles per outcome
`define CYCLES_NO_SKIP 2'h1
`define CYCLES_SKIP 2'h2
`define CYCLES_RESET 2'h0
// Steps and masks
`define PC_STEP 8'h01
`define BIT_BASE 8'h01
`endif

// ==== tb_skip_decrement_and_set_ops.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_skip_decrement_and_set_ops;
  logic sys_clk = 1'b0, reset = 1'b1, op_valid = 1'b0, mem_we, discard_prefetch, pc_advance;
  logic busy, s;
  logic [1:0] op_code = 2'h0, op_cycles;
  logic [2:0] op_bit = 3'h0;
  logic [7:0] op_addr = 8'h00, mem_rdata = 8'h00, pc_in = 8'h10, mem_addr, mem_wdata, pc_next;
  int error_cnt = 0, compares = 0;
  // Code, read data, bit, expected write data; a no-op keeps the last data
  logic [20:0] rows [7] = '{{2'h1, 8'h05, 3'h0, 8'h04}, {2'h1, 8'h01, 3'h0, 8'h00},
    {2'h1, 8'h00, 3'h0, 8'hFF}, {2'h2, 8'h12, 3'h0, 8'hFF}, {2'h3, 8'h80, 3'h7, 8'h80},
    {2'h3, 8'h5A, 3'h0, 8'h5B}, {2'h0, 8'h33, 3'h2, 8'h5B}};
  skip_decrement_and_set_ops skip_decrement_and_set_ops_i(
    .sys_clk(sys_clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .op_addr(op_addr), .op_bit(op_bit), .mem_rdata(mem_rdata), .pc_in(pc_in),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .discard_prefetch(discard_prefetch), .pc_advance(pc_advance), .pc_next(pc_next),
    .busy(busy), .op_cycles(op_cycles));
  task complete_run;
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial forever #5 sys_clk = ~sys_clk;
  // ****************************************
  // Stimulus
  // ****************************************
  initial
  begin
    repeat (10) @(negedge sys_clk);
    `CHK("reset we", 1'b0, mem_we)
    `CHK("reset busy", 1'b0, busy)
    `CHK("reset advance", 1'b0, pc_advance)
    reset = 0;
    foreach (rows[k])
    begin
      {op_code, mem_rdata, op_bit} = rows[k][20:8];
      op_addr = op_addr + 8'h11;
      op_valid = 1;
      s = op_code == 2'h1 && mem_rdata == 8'h01;
      @(negedge sys_clk);
      op_valid = 0;
      `CHK("we", op_code != 2'h0, mem_we)
      `CHK("addr", op_addr, mem_addr)
      `CHK("wdata", rows[k][7:0], mem_wdata)
      `CHK("skip", s, discard_prefetch)
      `CHK("busy", s, busy)
      `CHK("cycles", 2'h1 + s, op_cycles)
      `CHK("advance", 1'b1, pc_advance)
      `CHK("pc", pc_in + 8'h01, pc_next)
      @(negedge sys_clk);
      `CHK("dummy step", s, pc_advance)
      `CHK("dummy end", 1'b0, busy)
      `CHK("one write", 1'b0, mem_we)
    end
    // Op held through the dummy cycle must wait one cycle
    {op_code, mem_rdata, op_valid} = {2'h1, 8'h01, 1'b1};
    @(negedge sys_clk);
    op_code = 2'h2;
    @(negedge sys_clk);
    `CHK("refused", 1'b0, mem_we)
    `CHK("dummy", 1'b1, pc_advance)
    @(negedge sys_clk);
    `CHK("after", 1'b1, mem_we)
    `CHK("after data", 8'hFF, mem_wdata)
    // Reset in the middle of a skip clears the dummy slot
    {op_code, mem_rdata} = {2'h1, 8'h01};
    @(negedge sys_clk);
    `CHK("skip busy", 1'b1, busy)
    reset = 1;
    @(negedge sys_clk);
    `CHK("mid busy", 1'b0, busy)
    `CHK("mid skip", 1'b0, discard_prefetch)
    `CHK("mid cycles", 2'h0, op_cycles)
    {reset, op_code, mem_rdata, op_bit} = {1'b0, 2'h3, 8'h0F, 3'h5};
    @(negedge sys_clk);
    `CHK("first we", 1'b1, mem_we)
    `CHK("first op", 8'h2F, mem_wdata)
    complete_run();
  end
endmodule
`default_nettype wire
